// ### rtl/msc_defs.vh
// Constants of the modem serial command port: offsets, fields, resets.
// Assumes a single APB clock domain and word-aligned 32-bit registers.
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH

// ****************************************
// Register map
// ****************************************
`define MSC_ADDR_CMD 12'h000
`define MSC_ADDR_MODE 12'h004
`define MSC_ADDR_CTRL 12'h008
`define MSC_ADDR_TONE 12'h00C
`define MSC_CTRL_RESET 2'h1

// ****************************************
// Command fields
// ****************************************
`define MSC_CMD_BITS 7
`define MSC_CMD_GROUP 6
`define MSC_CMD_VALUE 5
`define MSC_CMD_EXT 4

// ****************************************
// Mode vector layout
// ****************************************
`define MSC_MODE_W 27
`define MSC_M_TONE 5'h00
`define MSC_M_FORCE_MARK 5'h01
`define MSC_M_TXL0 5'h02
`define MSC_M_TXL1 5'h03
`define MSC_M_TX_ON 5'h04
`define MSC_M_ALB 5'h05
`define MSC_M_CPM 5'h06
`define MSC_M_CI 5'h07
`define MSC_M_AUD0 5'h08
`define MSC_M_AUD1 5'h09
`define MSC_M_WL0 5'h0A
`define MSC_M_WL1 5'h0B
`define MSC_M_SYNC 5'h0C
`define MSC_M_LOW_SPEED 5'h0D
`define MSC_M_ANSWER 5'h0E
`define MSC_M_TX_MARK 5'h0F
`define MSC_M_TX_SPACE 5'h10
`define MSC_M_SCR_DIS 5'h11
`define MSC_M_DLB 5'h12
`define MSC_M_DOT 5'h13
`define MSC_M_LOCKED 5'h14
`define MSC_M_EXTERNAL 5'h15
`define MSC_M_T2100 5'h16
`define MSC_M_T1300 5'h17
`define MSC_M_V21 5'h18
`define MSC_M_ROW_DIS 5'h19
`define MSC_M_COL_DIS 5'h1A
`define MSC_MODE_RESET 27'h0000802

`endif

// ### rtl/msc_sync3.v
// Three-stage synchroniser with change detection on stages two and three differing.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/10ps
module msc_sync3 #(
	parameter RESET_VAL = 1'b0
) (
	input wire pclk,
	input wire presetn,
	input wire async_in,
	output wire level,
	output wire rise,
	output wire fall
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;

	// Capture chain, first stage feeds only the second
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= RESET_VAL;
			s2_reg <= RESET_VAL;
			s3_reg <= RESET_VAL;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// A change counts once stages two and three differ
	assign level = s3_reg;
	assign rise = s2_reg & ~s3_reg;
	assign fall = ~s2_reg & s3_reg;
endmodule

// ### rtl/msc_mode_decode.v
// Command decoder holding the modem mode settings and tone state.
// Assumes cmd_valid is a one-cycle pulse with a stable cmd word.
`timescale 1ns/10ps
`include "msc_defs.vh"
module msc_mode_decode (
	input wire pclk,
	input wire presetn,
	input wire cmd_valid,
	input wire [6:0] cmd,
	input wire soft_reset,
	output reg [26:0] mode_reg,
	output reg [3:0] dial_digit_reg,
	output reg dial_strobe_reg,
	output reg [1:0] guard_reg
);
	reg [26:0] mode_next;
	reg [4:0] idx;
	reg hit;
	reg val;
	wire [3:0] code;
	wire group;
	wire ext;

	assign code = cmd[3:0];
	assign group = cmd[`MSC_CMD_GROUP];
	assign ext = cmd[`MSC_CMD_EXT];

	// Map a non-tone command onto one mode bit
	always @* begin
		hit = 1'b1;
		idx = 5'h00;
		case ({ext, code})
			5'h01: idx = `MSC_M_TONE;
			5'h02: idx = `MSC_M_FORCE_MARK;
			5'h03: idx = `MSC_M_TXL0;
			5'h04: idx = `MSC_M_TXL1;
			5'h05: idx = `MSC_M_TX_ON;
			5'h06: idx = `MSC_M_ALB;
			5'h07: idx = `MSC_M_CPM;
			5'h08: idx = `MSC_M_CI;
			5'h09: idx = `MSC_M_AUD0;
			5'h0A: idx = `MSC_M_AUD1;
			5'h0B: idx = `MSC_M_WL0;
			5'h0C: idx = `MSC_M_WL1;
			5'h0D: idx = `MSC_M_SYNC;
			5'h0E: idx = `MSC_M_LOW_SPEED;
			5'h0F: idx = `MSC_M_ANSWER;
			5'h10: idx = `MSC_M_TX_MARK;
			5'h11: idx = `MSC_M_TX_SPACE;
			5'h12: idx = `MSC_M_SCR_DIS;
			5'h13: idx = `MSC_M_DLB;
			5'h14: idx = `MSC_M_DOT;
			5'h15: idx = `MSC_M_LOCKED;
			5'h16: idx = `MSC_M_EXTERNAL;
			5'h17: idx = `MSC_M_T2100;
			5'h18: idx = `MSC_M_T1300;
			5'h19: idx = `MSC_M_V21;
			default: hit = 1'b0;
		endcase
		// Force-mark names Off first, so its polarity is inverted
		val = cmd[`MSC_CMD_VALUE] ^ (idx == `MSC_M_FORCE_MARK);
		mode_next = mode_reg;
		if (!group && hit) begin
			mode_next[idx] = val;
		end
		if (group && !ext && code == 4'hE) begin
			mode_next[`MSC_M_ROW_DIS] = cmd[`MSC_CMD_VALUE];
		end
		if (group && !ext && code == 4'hF) begin
			mode_next[`MSC_M_COL_DIS] = cmd[`MSC_CMD_VALUE];
		end
	end

	// Settings, dial digit and guard tone selection
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= `MSC_MODE_RESET;
			dial_digit_reg <= 4'h0;
			dial_strobe_reg <= 1'b0;
			guard_reg <= 2'h0;
		end else begin
			dial_strobe_reg <= 1'b0;
			if (soft_reset) begin
				mode_reg <= `MSC_MODE_RESET;
				guard_reg <= 2'h0;
			end else if (cmd_valid) begin
				if (!group && !ext && code == 4'h0) begin
					mode_reg <= `MSC_MODE_RESET;
					guard_reg <= 2'h0;
				end else begin
					mode_reg <= mode_next;
				end
				if (group && !ext && code <= 4'hB) begin
					dial_digit_reg <= code;
					dial_strobe_reg <= 1'b1;
				end
				if (group && !ext && code == 4'hC) begin
					guard_reg <= {1'b0, cmd[`MSC_CMD_VALUE]};
				end
				if (group && !ext && code == 4'hD) begin
					guard_reg <= {cmd[`MSC_CMD_VALUE], 1'b0};
				end
			end
		end
	end
endmodule

// ### rtl/msc_top.v
// Serial command write port of a low-speed modem with APB access.
// Assumes strobe, shift clock and data come from an outside controller
// and are asynchronous to pclk; APB runs on pclk at 10 MHz.
`timescale 1ns/10ps
`include "msc_defs.vh"
module msc_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output reg [31:0] prdata,
	input wire wr_strobe_n,
	input wire shift_clk,
	input wire serial_data,
	output wire tone_on,
	output wire force_rx_mark,
	output wire tx_level_bit0,
	output wire tx_level_bit1,
	output wire tx_enable,
	output wire analog_loopback,
	output wire call_progress_monitor,
	output wire connection_indicator,
	output wire audio_level_bit0,
	output wire audio_level_bit1,
	output wire char_length_bit0,
	output wire char_length_bit1,
	output wire sync_mode,
	output wire speed_select,
	output wire answer_mode,
	output wire tx_mark,
	output wire tx_space,
	output wire scrambler_disable,
	output wire digital_loopback,
	output wire dotting_pattern_send,
	output wire clk_locked,
	output wire clk_external,
	output wire tone_2100,
	output wire tone_1300,
	output wire v21_mode,
	output wire row_disable,
	output wire col_disable,
	output wire [3:0] dial_digit,
	output wire dial_strobe,
	output wire guard_550,
	output wire guard_1800
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	wire wr_level;
	wire wr_rise;
	wire wr_fall;
	wire sck_rise;
	wire data_level;

	msc_sync3 #(.RESET_VAL(1'b1)) u_sync_wr (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(wr_strobe_n),
		.level(wr_level),
		.rise(wr_rise),
		.fall(wr_fall)
	);

	msc_sync3 #(.RESET_VAL(1'b0)) u_sync_sck (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(shift_clk),
		.level(),
		.rise(sck_rise),
		.fall()
	);

	msc_sync3 #(.RESET_VAL(1'b0)) u_sync_data (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(serial_data),
		.level(data_level),
		.rise(),
		.fall()
	);

	// ****************************************
	// Serial shift path
	// ****************************************
	reg [6:0] shift_reg;
	reg [2:0] count_reg;
	reg in_frame_reg;
	reg [6:0] cmd_reg;
	reg [2:0] cmd_len_reg;
	reg cmd_valid_reg;
	reg overflow_reg;
	reg empty_reg;
	reg port_en_reg;
	reg [31:0] cmd_count_reg;
	wire over_set;
	wire over_clr;
	wire empty_set;
	wire empty_clr;
	wire soft_reset;

	// A bit is taken on a clock rise only while the strobe is low
	wire take_bit;
	assign take_bit = in_frame_reg & ~wr_level & sck_rise;

	// Bits past the seventh are dropped and flagged
	assign over_set = take_bit & (count_reg == 3'h7);

	// Strobe rise with no bits shifted is recorded, not applied
	assign empty_set = in_frame_reg & wr_rise & (count_reg == 3'h0);

	// Frame tracking and LSB-first placement
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_reg <= 7'h00;
			count_reg <= 3'h0;
			in_frame_reg <= 1'b0;
		end else begin
			if (wr_fall && port_en_reg) begin
				shift_reg <= 7'h00;
				count_reg <= 3'h0;
				in_frame_reg <= 1'b1;
			end else if (wr_rise) begin
				in_frame_reg <= 1'b0;
			end else if (take_bit && count_reg != 3'h7) begin
				shift_reg[count_reg] <= data_level;
				count_reg <= count_reg + 3'h1;
			end
		end
	end

	// Holding latch, loaded as the strobe returns high
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg <= 7'h00;
			cmd_len_reg <= 3'h0;
			cmd_valid_reg <= 1'b0;
			cmd_count_reg <= 32'h00000000;
		end else begin
			cmd_valid_reg <= 1'b0;
			if (in_frame_reg && wr_rise && count_reg != 3'h0) begin
				cmd_reg <= shift_reg;
				cmd_len_reg <= count_reg;
				cmd_valid_reg <= 1'b1;
				cmd_count_reg <= cmd_count_reg + 32'h00000001;
			end
		end
	end

	// ****************************************
	// Mode settings
	// ****************************************
	wire [26:0] mode;
	wire [3:0] dial_digit_w;
	wire [1:0] guard;

	msc_mode_decode u_decode (
		.pclk(pclk),
		.presetn(presetn),
		.cmd_valid(cmd_valid_reg),
		.cmd(cmd_reg),
		.soft_reset(soft_reset),
		.mode_reg(mode),
		.dial_digit_reg(dial_digit_w),
		.dial_strobe_reg(dial_strobe),
		.guard_reg(guard)
	);

	// Settings out to the modem core
	assign tone_on = mode[`MSC_M_TONE];
	assign force_rx_mark = mode[`MSC_M_FORCE_MARK];
	assign tx_level_bit0 = mode[`MSC_M_TXL0];
	assign tx_level_bit1 = mode[`MSC_M_TXL1];
	assign tx_enable = mode[`MSC_M_TX_ON];
	assign analog_loopback = mode[`MSC_M_ALB];
	assign call_progress_monitor = mode[`MSC_M_CPM];
	assign connection_indicator = mode[`MSC_M_CI];
	assign audio_level_bit0 = mode[`MSC_M_AUD0];
	assign audio_level_bit1 = mode[`MSC_M_AUD1];
	assign char_length_bit0 = mode[`MSC_M_WL0];
	assign char_length_bit1 = mode[`MSC_M_WL1];
	assign sync_mode = mode[`MSC_M_SYNC];
	assign speed_select = mode[`MSC_M_LOW_SPEED];
	assign answer_mode = mode[`MSC_M_ANSWER];
	assign tx_mark = mode[`MSC_M_TX_MARK];
	assign tx_space = mode[`MSC_M_TX_SPACE];
	assign scrambler_disable = mode[`MSC_M_SCR_DIS];
	assign digital_loopback = mode[`MSC_M_DLB];
	assign dotting_pattern_send = mode[`MSC_M_DOT];
	assign clk_locked = mode[`MSC_M_LOCKED];
	assign clk_external = mode[`MSC_M_EXTERNAL];
	assign row_disable = mode[`MSC_M_ROW_DIS];
	assign col_disable = mode[`MSC_M_COL_DIS];
	assign dial_digit = dial_digit_w;
	assign guard_550 = guard[0];
	assign guard_1800 = guard[1];

	// Answer, calling tone and V.21 act only in low speed
	assign tone_2100 = mode[`MSC_M_T2100] & mode[`MSC_M_LOW_SPEED];
	assign tone_1300 = mode[`MSC_M_T1300] & mode[`MSC_M_LOW_SPEED];
	assign v21_mode = mode[`MSC_M_V21] & mode[`MSC_M_LOW_SPEED];

	// ****************************************
	// APB slave
	// ****************************************
	wire setup;
	wire access;
	wire wr_ctrl;
	wire mapped;

	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign mapped = (paddr == `MSC_ADDR_CMD) | (paddr == `MSC_ADDR_MODE) |
		(paddr == `MSC_ADDR_CTRL) | (paddr == `MSC_ADDR_TONE);

	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign wr_ctrl = access & pwrite & (paddr == `MSC_ADDR_CTRL);

	// Control write: bit0 port enable, bit1 mode reset, bits 2/3 clear
	assign soft_reset = wr_ctrl & pwdata[`MSC_CTRL_RESET];
	assign over_clr = wr_ctrl & pwdata[2];
	assign empty_clr = wr_ctrl & pwdata[3];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_en_reg <= 1'b1;
		end else if (wr_ctrl) begin
			port_en_reg <= pwdata[0];
		end
	end

	// Sticky flags: a new event wins over a clear in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_reg <= 1'b0;
			empty_reg <= 1'b0;
		end else begin
			overflow_reg <= over_set | (overflow_reg & ~over_clr);
			empty_reg <= empty_set | (empty_reg & ~empty_clr);
		end
	end

	// Read data captured in the setup cycle, valid in the access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup && !pwrite) begin
			case (paddr)
				`MSC_ADDR_CMD:
					prdata <= {cmd_count_reg[15:0], in_frame_reg,
						count_reg, 1'b0, cmd_len_reg, 1'b0, cmd_reg};
				`MSC_ADDR_MODE:
					prdata <= {5'h00, mode};
				`MSC_ADDR_CTRL:
					prdata <= {28'h0000000, empty_reg, overflow_reg,
						1'b0, port_en_reg};
				`MSC_ADDR_TONE:
					prdata <= {26'h0000000, guard, dial_digit_w};
				default:
					prdata <= 32'h00000000;
			endcase
		end
	end
endmodule

// ### test/msc_monitor.sv
// Checker of the command port: APB answers and mode output relations.
// Assumes it is bound into msc_top and sees only its ports.
`timescale 1ns/10ps
module msc_monitor (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire pready,
	input wire pslverr,
	input wire wr_strobe_n,
	input wire force_rx_mark,
	input wire char_length_bit1,
	input wire tx_level_bit0,
	input wire speed_select,
	input wire tone_2100,
	input wire tone_1300,
	input wire v21_mode,
	input wire dial_strobe,
	input wire guard_550,
	input wire guard_1800
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase and decode of the four mapped words
	wire acc = psel && penable;
	wire mapped = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);
	// Relations between the ports
	a_zero_wait: assert property (acc |-> pready)
		else $error("access cycle without ready");
	a_err_map: assert property (acc |-> pslverr == !mapped)
		else $error("error response does not match address decode");
	a_err_access: assert property (pslverr |-> acc)
		else $error("error response outside access phase");
	a_slow_tones: assert property ((tone_2100 || tone_1300 || v21_mode) |-> speed_select)
		else $error("low speed tone active at high speed");
	a_guard_single: assert property (!(guard_550 && guard_1800))
		else $error("both guard tones active");
	a_reset_default: assert property ($rose(presetn) |-> force_rx_mark && char_length_bit1 && !tx_level_bit0)
		else $error("modes not at defaults after reset");
	a_apply_late: assert property ($changed({force_rx_mark, char_length_bit1, tx_level_bit0})
		&& !$past(acc && pwrite) && !$past(acc && pwrite, 2) |-> $past(wr_strobe_n, 4))
		else $error("mode changed before strobe rose");
	a_dial_pulse: assert property (dial_strobe |-> $past(wr_strobe_n, 4) ##1 !dial_strobe)
		else $error("dial strobe not a single pulse after strobe rise");
	// Main scenarios reached
	cover property (dial_strobe);
	cover property (guard_1800);
	cover property (pslverr);
	cover property (tone_2100);
endmodule

bind msc_top msc_monitor msc_monitor_i (.*);

// ### test/msc_ctrl_model.sv
// Outside controller: drives write strobe, shift clock and data pins.
// Assumes the bench calls send; shift clock period 800 ns, free phase.
`timescale 1ns/10ps
module msc_ctrl_model (
	output logic wr_strobe_n,
	output logic shift_clk,
	output logic serial_data
);
	// Idle pins: strobe high, shift clock standing low
	initial begin
		wr_strobe_n = 1'b1;
		shift_clk = 1'b0;
		serial_data = 1'b0;
	end
	// One frame of n bits, bit 0 first, data set half a period before each rise
	task send(input [7:0] c, input int n);
		wr_strobe_n = 1'b0;
		#413;
		for (int i = 0; i < n; i++) begin
			serial_data = c[i];
			#400 shift_clk = 1'b1;
			#400 shift_clk = 1'b0;
		end
		// Released data line shows no stale level
		serial_data = ~serial_data;
		#400 wr_strobe_n = 1'b1;
		#400;
	endtask
endmodule

// ### test/testbench.sv
// Bench of the command port: APB master tasks and serial frames.
// Assumes msc_top and msc_ctrl_model; pclk 100 ns.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, rd;
	logic [26:0] ex;
	logic [7:0] c;
	int err_count = 0, n_compared = 0, n_dial = 0;
	wire pready, pslverr, wr_strobe_n, shift_clk, serial_data, dial_strobe, guard_550, guard_1800;
	wire [31:0] prdata;
	wire [3:0] dial_digit;
	wire tone_on, force_rx_mark, tx_level_bit0, tx_level_bit1, tx_enable, analog_loopback;
	wire call_progress_monitor, connection_indicator, audio_level_bit0, audio_level_bit1;
	wire char_length_bit0, char_length_bit1, sync_mode, speed_select, answer_mode, tx_mark;
	wire tx_space, scrambler_disable, digital_loopback, dotting_pattern_send, clk_locked;
	wire clk_external, tone_2100, tone_1300, v21_mode, row_disable, col_disable;
	wire [26:0] pv = {col_disable, row_disable, v21_mode, tone_1300, tone_2100, clk_external,
		clk_locked, dotting_pattern_send, digital_loopback, scrambler_disable, tx_space, tx_mark,
		answer_mode, speed_select, sync_mode, char_length_bit1, char_length_bit0,
		audio_level_bit1, audio_level_bit0, connection_indicator, call_progress_monitor,
		analog_loopback, tx_enable, tx_level_bit1, tx_level_bit0, force_rx_mark, tone_on};
	// Rows: mode bit index, command with value bit one
	logic [15:0] rows [27] = '{16'h0021, 16'h0122, 16'h0223, 16'h0324, 16'h0425, 16'h0526,
		16'h0627, 16'h0728, 16'h0829, 16'h092A, 16'h0A2B, 16'h0B2C, 16'h0C2D, 16'h0D2E,
		16'h0E2F, 16'h0F30, 16'h1031, 16'h1132, 16'h1233, 16'h1334, 16'h1435, 16'h1536,
		16'h1637, 16'h1738, 16'h1839, 16'h196E, 16'h1A6F};
	msc_top msc_top_i (.*);
	msc_ctrl_model msc_ctrl_model_i (.*);
	// Clock and dial pulse count
	initial forever #50 pclk = ~pclk;
	always @(posedge pclk) if (dial_strobe === 1'b1) n_dial++;
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// APB transfer held until pready is sampled high
	task apb(input w, input [11:0] a, input [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			err_count++;
			give_verdict;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Frame, then let the strobe rise reach the outputs
	task frame(input [7:0] f, input int n);
		msc_ctrl_model_i.send(f, n);
		repeat (6) @(posedge pclk);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		ex = 27'h0000802;
		apb(0, 12'h004, 0);
		`CHK("mode reset", 32'h00000802, rd)
		apb(0, 12'h008, 0);
		`CHK("ctrl reset", 32'h00000001, rd)
		for (int p = 0; p < 2; p++) begin
			for (int r = 0; r < 27; r++) begin
				c = rows[r][7:0] ^ ((p == 1) ? 8'h20 : 8'h00);
				frame(c, 7);
				ex[rows[r][15:8]] = (p == 0) ^ (rows[r][15:8] == 8'h01);
				apb(0, 12'h004, 0);
				`CHK("mode", {5'h00, ex}, rd)
				`CHK("pins", ex & {2'h3, {3{ex[13]}}, 22'h3FFFFF}, pv)
				apb(0, 12'h000, 0);
				`CHK("cmd", {3'h7, c[6:0]}, {rd[10:8], rd[6:0]})
			end
		end
		frame(8'h20, 7);
		apb(0, 12'h004, 0);
		`CHK("mode cleared", 32'h00000802, rd)
		apb(0, 12'h010, 0);
		`CHK("unmapped", 33'h100000000, {er, rd})
		apb(1, 12'h004, 32'hFFFFFFFF);
		apb(0, 12'h004, 0);
		`CHK("mode ro", 32'h00000802, rd)
		for (int d = 0; d < 12; d++) begin
			frame(8'h40 | d[7:0], 7);
			`CHK("digit", d[3:0], dial_digit)
		end
		`CHK("dial pulses", 12, n_dial)
		for (int g = 0; g < 3; g++) begin
			frame((g == 0) ? 8'h6C : (g == 1) ? 8'h6D : 8'h4D, 7);
			apb(0, 12'h00C, 0);
			`CHK("tone", {(g == 0) ? 2'h1 : (g == 1) ? 2'h2 : 2'h0, 4'hB}, rd[5:0])
		end
		frame(8'h21, 7);
		apb(1, 12'h008, 32'h00000003);
		apb(0, 12'h004, 0);
		`CHK("mode restore", 32'h00000802, rd)
		frame(8'hA1, 8);
		frame(8'h00, 0);
		apb(0, 12'h000, 0);
		`CHK("cmd overflow", {3'h7, 7'h21}, {rd[10:8], rd[6:0]})
		apb(0, 12'h008, 0);
		`CHK("ctrl flags", 32'h0000000D, rd)
		apb(1, 12'h008, 32'h0000000D);
		apb(0, 12'h008, 0);
		`CHK("ctrl w1c", 32'h00000001, rd)
		apb(1, 12'h008, 32'h00000000);
		frame(8'h20, 7);
		apb(0, 12'h004, 0);
		`CHK("mode port off", 32'h00000803, rd)
		apb(1, 12'h008, 32'h00000001);
		frame(8'h21, 7);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h004, 0);
		`CHK("mode rereset", 32'h00000802, rd)
		give_verdict;
	end
endmodule
